// ---- verilog/position_loop_defs.svh ----
// Register offsets, setting limits, reset values and timing counts
`ifndef POSITION_LOOP_DEFS_SVH
`define POSITION_LOOP_DEFS_SVH
`define OFS_INPOS_WIDTH 8'h00
`define OFS_EXCESS_LEVEL 8'h04
`define OFS_LOOP_GAIN 8'h08
`define OFS_FF_GAIN 8'h0C
`define OFS_FF_FILTER 8'h10
`define OFS_TUNE_SEL 8'h14
`define OFS_STATUS 8'h18
`define OFS_DROOP 8'h1C
`define OFS_TERM_BASE 8'h20
`define NUM_TERMS 7
`define MAX_INPOS_WIDTH 32'h0000_7FFF
`define MAX_EXCESS_LEVEL 32'h0000_0190
`define MAX_LOOP_GAIN 32'h0000_0096
`define MAX_FF_GAIN 32'h0000_0064
`define MAX_FF_FILTER_MS 32'h0000_1388
`define PANEL_MAX 32'h0000_270F
`define LEVEL_OFF 32'h0000_270F
`define LEVEL_UNIT 32'h0000_03E8
`define RST_INPOS_WIDTH 32'h0000_0064
`define RST_EXCESS_LEVEL 32'h0000_0028
`define RST_LOOP_GAIN 32'h0000_0019
`define RST_FF_GAIN 32'h0000_0000
`define RST_FF_FILTER 32'h0000_0000
`define RST_TUNE_SEL 32'h0000_0000
`define RST_TERM_FUNC 16'h270F
`define FUNC_INPOS_HIGH 16'h0024
`define FUNC_INPOS_LOW 16'h0088
`define STAT_INPOS 0
`define STAT_FAULT 1
`define STAT_CARD 2
`define CLK_PERIOD_NS 4
`define CTRL_TICK_NS 1000
`define CTRL_TICK_CYCLES (`CTRL_TICK_NS / `CLK_PERIOD_NS)
`define TICKS_PER_SEC 32'h000F_4240
`define TICKS_PER_MS 32'h0000_03E8
`define PCT_FULL 32'h0000_0064
`endif

// ---- verilog/position_loop_pkg.sv ----
// Shared types of the position loop supervisor
package position_loop_pkg;
  typedef logic signed [31:0] droop_t;
  typedef logic [31:0] setting_t;
  typedef logic signed [47:0] speed_t;
  typedef logic [15:0] func_t;
endpackage : position_loop_pkg

// ---- verilog/droop_threshold_cmp.sv ----
// Magnitude compare of the droop count against both thresholds
`timescale 1ns/1ps
`include "position_loop_defs.svh"
module droop_threshold_cmp
  import position_loop_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire droop_t droop,
  input wire setting_t inPosWidth,
  input wire setting_t excessLevel,
  output logic inPosFlag,
  output logic excessRaw
);
  logic [31:0] mag;
  logic [31:0] limit;
  assign mag = droop[31] ? 32'(-droop) : 32'(droop);
  assign limit = 32'(excessLevel * `LEVEL_UNIT);
  // RULE16 - unsigned compare of droop magnitude
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      inPosFlag <= 1'b0;
      excessRaw <= 1'b0;
    end else begin
      // RULE1 - below width
      inPosFlag <= mag < inPosWidth;
      // RULE4 - disabled level
      excessRaw <= (excessLevel != `LEVEL_OFF) && (mag > limit);
    end
  end
endmodule : droop_threshold_cmp

// ---- verilog/ff_lag_filter.sv ----
// First-order lag applied to the feed-forward command
`timescale 1ns/1ps
`include "position_loop_defs.svh"
module ff_lag_filter
  import position_loop_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick,
  input wire speed_t ffIn,
  input wire setting_t tauMs,
  output speed_t ffOut
);
  logic [24:0] den;
  logic signed [48:0] diff;
  logic signed [48:0] step;
  // Divider is wide but only needs to settle within one tick
  assign den = 25'(tauMs * `TICKS_PER_MS) + 25'd1;
  assign diff = 49'(ffIn) - 49'(ffOut);
  assign step = diff / $signed({24'd0, den});
  // RULE9 - lag filter update
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ffOut <= '0;
    end else if (tick) begin
      ffOut <= 48'(49'(ffOut) + step);
    end
  end
endmodule : ff_lag_filter

// ---- verilog/position_loop_supervisor.sv ----
// Position loop supervision, gain stage and setting registers
// How it works
// RULE1 - In-position flag set while droop magnitude is below in-position width
// RULE2 - Terminal shows the flag for code 36 high, code 136 low
// RULE3 - Droop beyond excess level raises fault, trips and zeroes speed output
// RULE4 - Excess level 9999 disables the excess position error fault
// RULE5 - Loop settings are writable only with the encoder card fitted
// RULE6 - Panel writes are capped at 9999; full unit gets whole range
// RULE7 - Droop scaled by loop gain, 0 to 150 per second, reset 25
// RULE8 - Feed-forward weight 0 to 100 percent, reset 0
// RULE9 - Feed-forward passes a lag filter, 0 to 5 s, reset 0
// RULE10 - Feed-forward follows command rate only, not droop stiffness
// RULE11 - Operator zeroes the tuning selector before gain writes
// RULE12 - Operator tunes gain in steps of 3, settles at 0.8 to 0.9
// RULE13 - Operator keeps loop gain roughly within 5 to 50
// RULE14 - Operator raises excess level when lowering loop gain
// RULE15 - Deviation counter sums command minus feedback pulses
// RULE16 - Droop magnitude compared against both thresholds every cycle
`timescale 1ns/1ps
`include "position_loop_defs.svh"
module position_loop_supervisor
  import position_loop_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic panelWrite,
  input wire logic cardFitted,
  input wire logic servoOn,
  input wire logic cmdPulse,
  input wire logic cmdDir,
  input wire logic fbPulse,
  input wire logic fbDir,
  output logic [`NUM_TERMS-1:0] termOut,
  output logic excessFault,
  output logic outputOff,
  output speed_t speedCmd
);
  setting_t inPosWidth;
  setting_t excessLevel;
  setting_t loopGain;
  setting_t ffGain;
  setting_t ffFilter;
  setting_t tuneSel;
  func_t termFunc [`NUM_TERMS];
  droop_t droop;
  droop_t next_droop;
  droop_t winCount;
  droop_t cmdRate;
  logic [7:0] tickCnt;
  logic tick;
  logic inPosFlag;
  logic excessRaw;
  logic cardWr;
  speed_t ffRaw;
  speed_t ffFilt;
  speed_t next_speed;

  function automatic setting_t capSetting(input setting_t v,
                                          input setting_t maxV,
                                          input logic panel);
    setting_t lim;
    lim = maxV;
    if (panel && lim > `PANEL_MAX) begin
      lim = `PANEL_MAX;
    end
    capSetting = (v > lim) ? lim : v;
  endfunction : capSetting

  function automatic logic termDrive(input func_t code, input logic flag);
    if (code == `FUNC_INPOS_HIGH) begin
      termDrive = flag;
    end else if (code == `FUNC_INPOS_LOW) begin
      termDrive = !flag;
    end else begin
      termDrive = 1'b0;
    end
  endfunction : termDrive

  // RULE5 - card gates writes
  assign cardWr = regWr && cardFitted;

  // RULE6 - panel cap on width
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      inPosWidth <= `RST_INPOS_WIDTH;
    end else if (cardWr && regAddr == `OFS_INPOS_WIDTH) begin
      inPosWidth <= capSetting(regWrData, `MAX_INPOS_WIDTH, panelWrite);
    end
  end

  // RULE4 - keep the disable code
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      excessLevel <= `RST_EXCESS_LEVEL;
    end else if (cardWr && regAddr == `OFS_EXCESS_LEVEL) begin
      if (regWrData == `LEVEL_OFF) begin
        excessLevel <= `LEVEL_OFF;
      end else begin
        excessLevel <= capSetting(regWrData, `MAX_EXCESS_LEVEL, panelWrite);
      end
    end
  end

  // RULE7 - gain setting
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loopGain <= `RST_LOOP_GAIN;
    end else if (cardWr && regAddr == `OFS_LOOP_GAIN) begin
      loopGain <= capSetting(regWrData, `MAX_LOOP_GAIN, panelWrite);
    end
  end

  // RULE8 - feed-forward weight
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ffGain <= `RST_FF_GAIN;
      ffFilter <= `RST_FF_FILTER;
    end else if (cardWr && regAddr == `OFS_FF_GAIN) begin
      ffGain <= capSetting(regWrData, `MAX_FF_GAIN, panelWrite);
    end else if (cardWr && regAddr == `OFS_FF_FILTER) begin
      ffFilter <= capSetting(regWrData, `MAX_FF_FILTER_MS, panelWrite);
    end
  end

  // Selector is only stored; the operator must clear it before tuning
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tuneSel <= `RST_TUNE_SEL;
    end else if (regWr && regAddr == `OFS_TUNE_SEL) begin
      tuneSel <= regWrData;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_TERMS; g++) begin : gTerm
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          termFunc[g] <= `RST_TERM_FUNC;
        end else if (regWr && regAddr == `OFS_TERM_BASE + 8'(4 * g)) begin
          termFunc[g] <= regWrData[15:0];
        end
      end
      // RULE2 - terminal polarity
      assign termOut[g] = termDrive(termFunc[g], inPosFlag);
    end
  endgenerate

  // RULE15 - deviation counter
  always_comb begin
    next_droop = droop;
    if (cmdPulse) begin
      next_droop = cmdDir ? next_droop - 32'sd1 : next_droop + 32'sd1;
    end
    if (fbPulse) begin
      next_droop = fbDir ? next_droop + 32'sd1 : next_droop - 32'sd1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !servoOn || excessFault) begin
      droop <= '0;
    end else begin
      droop <= next_droop;
    end
  end

  droop_threshold_cmp uCmp (
    .clk_sys(clk_sys),
    .rst(rst),
    .droop(droop),
    .inPosWidth(inPosWidth),
    .excessLevel(excessLevel),
    .inPosFlag(inPosFlag),
    .excessRaw(excessRaw)
  );

  // RULE3 - sticky trip, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      excessFault <= 1'b0;
    end else if (excessRaw) begin
      excessFault <= 1'b1;
    end else if (regWr && regAddr == `OFS_STATUS &&
                 regWrData[`STAT_FAULT]) begin
      excessFault <= 1'b0;
    end
  end
  assign outputOff = excessFault;

  assign tick = tickCnt == 8'(`CTRL_TICK_CYCLES - 1);
  always_ff @(posedge clk_sys) begin
    if (rst || tick) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= tickCnt + 8'd1;
    end
  end

  // Command pulses per control tick give the command rate
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      winCount <= '0;
      cmdRate <= '0;
    end else if (tick) begin
      cmdRate <= winCount;
      // Pulse on the tick edge opens the next window, so none is lost
      winCount <= cmdPulse ? (cmdDir ? -32'sd1 : 32'sd1) : '0;
    end else if (cmdPulse) begin
      winCount <= cmdDir ? winCount - 32'sd1 : winCount + 32'sd1;
    end
  end

  // RULE10 - rate only, no droop
  assign ffRaw = 48'(48'(cmdRate) * $signed({16'd0, `TICKS_PER_SEC}) *
                 $signed({16'd0, ffGain}) / $signed({16'd0, `PCT_FULL}));

  ff_lag_filter uFilt (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick),
    .ffIn(ffRaw),
    .tauMs(ffFilter),
    .ffOut(ffFilt)
  );

  // RULE7 - proportional gain term
  assign next_speed = 48'(48'(droop) * $signed({16'd0, loopGain})) + ffFilt;

  // RULE3 - output shut off
  always_ff @(posedge clk_sys) begin
    if (rst || excessFault || !servoOn) begin
      speedCmd <= '0;
    end else begin
      speedCmd <= next_speed;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !regRd) begin
      regRdData <= '0;
    end else begin
      unique case (regAddr)
        `OFS_INPOS_WIDTH: regRdData <= inPosWidth;
        `OFS_EXCESS_LEVEL: regRdData <= excessLevel;
        `OFS_LOOP_GAIN: regRdData <= loopGain;
        `OFS_FF_GAIN: regRdData <= ffGain;
        `OFS_FF_FILTER: regRdData <= ffFilter;
        `OFS_TUNE_SEL: regRdData <= tuneSel;
        `OFS_STATUS: regRdData <= {29'd0, cardFitted, excessFault,
                                   inPosFlag};
        `OFS_DROOP: regRdData <= droop;
        default: begin
          regRdData <= '0;
          for (int i = 0; i < `NUM_TERMS; i++) begin
            if (regAddr == `OFS_TERM_BASE + 8'(4 * i)) begin
              regRdData <= {16'd0, termFunc[i]};
            end
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_inpos_high_term: assert property ( // RULE2
    termFunc[0] == `FUNC_INPOS_HIGH |-> termOut[0] == inPosFlag)
    else $error("terminal 0 does not follow in-position flag");
  chk_inpos_low_term: assert property ( // RULE2
    termFunc[0] == `FUNC_INPOS_LOW |-> termOut[0] == !inPosFlag)
    else $error("terminal 0 not inverted in-position flag");
  chk_inpos_width_compare: assert property ( // RULE1
    $stable(inPosWidth) && droop >= 0 && droop < $signed(inPosWidth)
    |=> inPosFlag)
    else $error("in-position flag missing below width");
  chk_excess_trip_raise: assert property ( // RULE3
    excessLevel != `LEVEL_OFF && $stable(excessLevel) &&
    (droop > $signed(excessLevel * `LEVEL_UNIT) ||
     -droop > $signed(excessLevel * `LEVEL_UNIT)) |=> ##1 excessFault)
    else $error("excess droop did not trip");
  chk_excess_fault_off: assert property ( // RULE4
    $past(excessLevel) == `LEVEL_OFF && excessLevel == `LEVEL_OFF
    |-> !excessRaw)
    else $error("excess fault raised while disabled");
  chk_card_write_guard: assert property ( // RULE5
    regWr && !cardFitted && regAddr <= `OFS_FF_FILTER
    |=> $stable(inPosWidth) && $stable(excessLevel) &&
    $stable(loopGain) && $stable(ffGain) && $stable(ffFilter))
    else $error("setting written without option card");
  chk_panel_write_cap: assert property ( // RULE6
    cardWr && panelWrite && regAddr == `OFS_INPOS_WIDTH
    |=> inPosWidth <= `PANEL_MAX)
    else $error("panel write exceeded cap");
  chk_gain_range_limit: assert property ( // RULE7
    loopGain <= `MAX_LOOP_GAIN && ffGain <= `MAX_FF_GAIN)
    else $error("gain setting out of range");
  chk_filter_range_limit: assert property ( // RULE9
    ffFilter <= `MAX_FF_FILTER_MS)
    else $error("filter setting out of range");
  chk_trip_shuts_output: assert property ( // RULE3
    excessFault |-> outputOff ##1 speedCmd == '0)
    else $error("output not shut off on trip");
  chk_droop_count_step: assert property ( // RULE15
    servoOn && !excessFault && cmdPulse && !cmdDir && !fbPulse
    |=> droop == $past(droop) + 32'sd1)
    else $error("deviation counter missed command pulse");
  chk_ff_stop_zero: assert property ( // RULE10
    ffGain == '0 && ffFilt == '0 && servoOn && !excessFault
    |=> speedCmd == 48'($past(droop) * $signed({16'd0, $past(loopGain)})))
    else $error("stiffness not set by gain alone");

  cov_inpos_reached: cover property (!inPosFlag ##1 inPosFlag);
  cov_excess_trip: cover property (!excessFault ##1 excessFault);
  cov_panel_capped: cover property (
    cardWr && panelWrite && regWrData > `PANEL_MAX &&
    regAddr == `OFS_INPOS_WIDTH);
  cov_fault_cleared: cover property (excessFault ##1 !excessFault);
endmodule : position_loop_supervisor

// ---- testbench/pulse_source_model.sv ----
// Command pulse source and encoder feedback model
`timescale 1ns/1ps
module pulse_source_model (
  input wire logic clk_sys,
  output logic cmdPulse,
  output logic cmdDir,
  output logic fbPulse,
  output logic fbDir
);
  logic busy = 1'b0;

  initial begin
    cmdPulse = 1'b0;
    cmdDir = 1'b0;
    fbPulse = 1'b0;
    fbDir = 1'b0;
  end

  // Idle direction lines wander, so a stale level is never trusted
  always @(posedge clk_sys) begin
    if (!busy) begin
      cmdDir <= ~cmdDir;
      fbDir <= ~fbDir;
    end
  end

  task automatic send(input int nCmd, input int nFb, input logic dir,
                      input int gap);
    int n;
    n = (nCmd > nFb) ? nCmd : nFb;
    busy = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      cmdPulse <= (i < nCmd);
      fbPulse <= (i < nFb);
      cmdDir <= dir;
      fbDir <= dir;
      // Slow source leaves idle cycles between pulses
      repeat (gap) begin
        @(posedge clk_sys);
        cmdPulse <= 1'b0;
        fbPulse <= 1'b0;
      end
    end
    @(posedge clk_sys);
    cmdPulse <= 1'b0;
    fbPulse <= 1'b0;
    busy = 1'b0;
  endtask : send
endmodule : pulse_source_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the position loop supervisor
`timescale 1ns/1ps
`include "position_loop_defs.svh"
module testbench import position_loop_pkg::*;;
  logic clk_sys;
  logic rst;
  logic regWr;
  logic regRd;
  logic panelWrite;
  logic cardFitted;
  logic servoOn;
  logic [7:0] regAddr;
  logic [31:0] regWrData;
  logic [31:0] regRdData;
  logic cmdPulse;
  logic cmdDir;
  logic fbPulse;
  logic fbDir;
  logic [`NUM_TERMS-1:0] termOut;
  logic excessFault;
  logic outputOff;
  speed_t speedCmd;
  speed_t expSpd;
  int failures = 0;
  int nChecks = 0;
  int g;
  logic [31:0] rnd = 32'h0000_d785;
  logic rdTaken = 1'b0;
  logic [31:0] expQ[$];
  logic [7:0] rAddr[8] = '{`OFS_INPOS_WIDTH, `OFS_EXCESS_LEVEL,
    `OFS_LOOP_GAIN, `OFS_FF_GAIN, `OFS_FF_FILTER, `OFS_TUNE_SEL,
    `OFS_TERM_BASE, 8'h40};
  logic [31:0] rExp[8] = '{32'h0000_0064, 32'h0000_0028, 32'h0000_0019,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_270F,
    32'h0000_0000};

  position_loop_supervisor position_loop_supervisor_i (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .panelWrite(panelWrite),
    .cardFitted(cardFitted), .servoOn(servoOn), .cmdPulse(cmdPulse),
    .cmdDir(cmdDir), .fbPulse(fbPulse), .fbDir(fbDir),
    .termOut(termOut), .excessFault(excessFault), .outputOff(outputOff),
    .speedCmd(speedCmd));

  pulse_source_model pulse_source_model_i (
    .clk_sys(clk_sys), .cmdPulse(cmdPulse), .cmdDir(cmdDir),
    .fbPulse(fbPulse), .fbDir(fbDir));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic end_sim;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_read

  task automatic cmp_port(input logic [47:0] got, input logic [47:0] exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_port

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    expQ.push_back(exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rdTaken) begin
      cmp_read(regRdData, expQ.pop_front());
    end
    rdTaken <= regRd;
  end

  initial begin
    repeat (6000) @(posedge clk_sys);
    failures++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0000_0000;
    panelWrite = 1'b0;
    cardFitted = 1'b1;
    servoOn = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(rAddr[i], rExp[i]);
    end
    cardFitted <= 1'b0;
    wr(`OFS_INPOS_WIDTH, 32'h0000_0007);
    rd(`OFS_INPOS_WIDTH, 32'h0000_0064);
    cardFitted <= 1'b1;
    panelWrite <= 1'b1;
    wr(`OFS_INPOS_WIDTH, 32'h0000_4E20);
    rd(`OFS_INPOS_WIDTH, `PANEL_MAX);
    panelWrite <= 1'b0;
    wr(`OFS_INPOS_WIDTH, 32'h0000_9C40);
    rd(`OFS_INPOS_WIDTH, `MAX_INPOS_WIDTH);
    // level raised ahead of gain change
    wr(`OFS_EXCESS_LEVEL, 32'h0000_01F4);
    rd(`OFS_EXCESS_LEVEL, `MAX_EXCESS_LEVEL);
    wr(`OFS_TUNE_SEL, 32'h0000_0000);
    rnd = lfsr(rnd);
    // gain on a 3-step grid from 5 to 50
    g = 5 + 3 * int'(rnd % 32'h0000_0010);
    wr(`OFS_LOOP_GAIN, 32'(g));
    rd(`OFS_LOOP_GAIN, 32'(g));
    wr(`OFS_INPOS_WIDTH, 32'h0000_0005);
    wr(`OFS_TERM_BASE, 32'h0000_0024);
    wr(`OFS_TERM_BASE + 8'h04, 32'h0000_0088);
    settle(2);
    cmp_port(48'(termOut), 48'h0000_0000_0001);
    pulse_source_model_i.send(5, 0, 1'b0, 2);
    settle(4);
    cmp_port(48'(termOut), 48'h0000_0000_0002);
    expSpd = 48'(5 * g);
    cmp_port(speedCmd, expSpd);
    rd(`OFS_DROOP, 32'h0000_0005);
    pulse_source_model_i.send(9, 0, 1'b1, 0);
    settle(4);
    cmp_port(48'(termOut), 48'h0000_0000_0001);
    expSpd = 48'(-4 * g);
    cmp_port(speedCmd, expSpd);
    rd(`OFS_DROOP, 32'hFFFF_FFFC);
    wr(`OFS_FF_GAIN, 32'h0000_0064);
    fork
      pulse_source_model_i.send(600, 600, 1'b0, 0);
      begin
        // Full window, then one more tick through the filter
        settle(700);
        cmp_port(speedCmd, expSpd + 48'h0000_0EE6_B280);
      end
    join
    settle(600);
    cmp_port(speedCmd, expSpd);
    wr(`OFS_EXCESS_LEVEL, 32'h0000_270F);
    settle(4);
    cmp_port(48'(excessFault), 48'h0000_0000_0000);
    rd(`OFS_EXCESS_LEVEL, `LEVEL_OFF);
    wr(`OFS_EXCESS_LEVEL, 32'h0000_0000);
    settle(4);
    cmp_port(48'({excessFault, outputOff}), 48'h0000_0000_0003);
    cmp_port(speedCmd, 48'h0000_0000_0000);
    wr(`OFS_STATUS, 32'h0000_0002);
    settle(3);
    cmp_port(48'(excessFault), 48'h0000_0000_0000);
    wr(`OFS_FF_FILTER, 32'h0000_2000);
    rd(`OFS_FF_FILTER, `MAX_FF_FILTER_MS);
    settle(2);
    end_sim();
  end
endmodule : testbench
